// >>> shared/tec_pkg.sv
package tec_pkg;
  // register indices; byte address is four times the index
  localparam logic [15:0] IDX_COUNT = 16'hFF12;
  localparam logic [15:0] IDX_CCF = 16'hFF14;
  localparam logic [15:0] IDX_CCS = 16'hFF16;
  localparam logic [15:0] IDX_MODE = 16'hFF18;
  localparam logic [15:0] IDX_CCCTL = 16'hFF19;
  localparam logic [15:0] IDX_OUTCTL = 16'hFF1A;
  localparam logic [15:0] IDX_PRESC = 16'hFF1B;
  localparam logic [15:0] IDX_STAT = 16'hFF1C;
  localparam logic [15:0] IDX_MASK = 16'hFF1D;
  localparam logic [17:0] A_COUNT = {IDX_COUNT, 2'h0};
  localparam logic [17:0] A_CCF = {IDX_CCF, 2'h0};
  localparam logic [17:0] A_CCS = {IDX_CCS, 2'h0};
  localparam logic [17:0] A_MODE = {IDX_MODE, 2'h0};
  localparam logic [17:0] A_CCCTL = {IDX_CCCTL, 2'h0};
  localparam logic [17:0] A_OUTCTL = {IDX_OUTCTL, 2'h0};
  localparam logic [17:0] A_PRESC = {IDX_PRESC, 2'h0};
  localparam logic [17:0] A_STAT = {IDX_STAT, 2'h0};
  localparam logic [17:0] A_MASK = {IDX_MASK, 2'h0};
  // field positions
  localparam int MODE_LSB = 2;
  localparam int CC_F_CAP = 0;
  localparam int CC_F_SRC = 1;
  localparam int CC_S_CAP = 2;
  localparam int OC_EN = 0;
  localparam int OC_OS_MODE = 1;
  localparam int OC_OS_TRIG = 2;
  localparam int OC_TGL_F = 3;
  localparam int OC_TGL_S = 4;
  localparam int OC_INIT = 5;
  localparam int PS_SEL_LSB = 0;
  localparam int ES0_LSB = 4;
  localparam int ES1_LSB = 6;
  // reset values
  localparam logic [15:0] RST_WORD = 16'h0000;
  localparam logic [7:0] RST_BYTE = 8'h00;
  // timing
  localparam int CLK_HZ = 200000000;
  localparam int PULSE_MIN_CYC = 2;
  localparam logic [7:0] DIV_MID_LAST = 8'h03;
  localparam logic [7:0] DIV_SLOW_LAST = 8'hFF;
  localparam logic [15:0] CNT_MAX = 16'hFFFF;
  typedef enum logic [1:0] {
    MODE_STOP = 2'b00,
    MODE_FREE = 2'b01,
    MODE_CLR_EDGE = 2'b10,
    MODE_CLR_MATCH = 2'b11
  } tec_mode_e;
  typedef enum logic [1:0] {
    CK_DIV1 = 2'b00,
    CK_DIV4 = 2'b01,
    CK_DIV256 = 2'b10,
    CK_EXT = 2'b11
  } tec_clk_e;
  typedef struct packed {
    logic ovf;
    logic second;
    logic first;
  } tec_irq_s;
endpackage

// >>> hw/tec_core.sv
// How it works
// - read-only 16-bit counter, plus one per selected count clock edge
// - a counter read halts count pulses and returns the held value
// - reset forces the counter to zero
// - both mode select bits clear stop the counter and clear it
// - edge clear mode: each valid first input edge zeroes the counter
// - match clear mode: counter returns to zero on first register match
// - one-shot mode: writing the trigger bit zeroes counter, starts shot
// - a counter read never loads the second capture/compare register
// - interval mode raises interrupts every 1 to 65536 count clocks
// - event counting; input levels need two clock periods
// - pulse width capture; measured levels need two clock periods
// - square wave period is twice the count times the clock period
// - pulse generator with separate period and width up to 65536
// - one-shot emits a single pulse of programmable width
// - counter, two capture/compare registers, two inputs, one output
// - first compare register match raises its own interrupt
// - second compare register match raises its own interrupt
// - compare below count: counter wraps past FFFF before matching
//
// The Avalon-MM interface to the registers was left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module tec_core
  import tec_pkg::*;
(
  // clock and reset
  input wire logic sys_clk_in,
  input wire logic arst_n_in,
  // avalon-mm slave
  input wire logic [17:0] avs_address_in,
  input wire logic avs_read_in,
  input wire logic avs_write_in,
  input wire logic [31:0] avs_writedata_in,
  input wire logic [3:0] avs_byteenable_in,
  output logic [31:0] avs_readdata_out,
  output logic avs_waitrequest_out,
  // timer pins
  input wire logic timer_input_first_in,
  input wire logic timer_input_second_in,
  output logic timer_output_pin_out,
  output logic timer_output_pin_oe_out,
  // interrupts
  output logic irq_out,
  output logic match_irq_first_out,
  output logic match_irq_second_out
);
  logic [15:0] cnt;
  logic [15:0] ccf;
  logic [15:0] ccs;
  logic [7:0] mode_reg;
  logic [7:0] ccctl;
  logic [7:0] outctl;
  logic [7:0] presc;
  tec_irq_s stat;
  tec_irq_s mask;
  tec_irq_s ev;
  tec_irq_s next_stat;
  tec_mode_e mode;
  tec_clk_e ck_sel;
  logic [7:0] pre_cnt;
  logic [1:0] ti_raw;
  logic [1:0] ti_lvl;
  logic [1:0] ti_prev;
  logic ev0;
  logic ev1;
  logic req;
  logic wr_acc;
  logic rd_acc;
  logic freeze;
  logic src;
  logic tick;
  logic os_trig_w;
  logic os_run;
  logic match_f;
  logic match_s;
  logic cap_f;
  logic cap_s;
  logic clr_match;

  assign mode = tec_mode_e'(mode_reg[MODE_LSB+:2]);
  assign ck_sel = tec_clk_e'(presc[PS_SEL_LSB+:2]);
  assign ti_raw = {timer_input_second_in, timer_input_first_in};
  assign req = avs_read_in | avs_write_in;
  assign wr_acc = avs_write_in & ~avs_waitrequest_out;
  assign rd_acc = avs_read_in & ~avs_waitrequest_out;

  // short glitches are dropped: a level counts once it held two samples
  for (genvar g = 0; g < 2; g++)
  begin : g_filt
    logic [PULSE_MIN_CYC-1:0] hist;
    logic [PULSE_MIN_CYC-1:0] filled;
    logic primed;
    always_ff @(posedge sys_clk_in or negedge arst_n_in)
    begin
      if (!arst_n_in)
      begin
        hist <= '0;
        filled <= '0;
        primed <= 1'b0;
        ti_lvl[g] <= 1'b0;
        ti_prev[g] <= 1'b0;
      end
      else
      begin
        hist <= {hist[PULSE_MIN_CYC-2:0], ti_raw[g]};
        filled <= {filled[PULSE_MIN_CYC-2:0], 1'b1};
        // first settled level seeds both stages: no false edge after reset
        if (!primed)
        begin
          if (&filled && (&hist || ~|hist))
          begin
            ti_lvl[g] <= hist[0];
            ti_prev[g] <= hist[0];
            primed <= 1'b1;
          end
        end
        else
        begin
          if (&hist || ~|hist)
            ti_lvl[g] <= hist[0];
          ti_prev[g] <= ti_lvl[g];
        end
      end
    end
  end

  function automatic logic edge_ok(input logic [1:0] es,
                                   input logic lvl, input logic prv);
    case (es)
      2'b00: edge_ok = ~lvl & prv;
      2'b01: edge_ok = lvl & ~prv;
      2'b11: edge_ok = lvl ^ prv;
      default: edge_ok = 1'b0;
    endcase
  endfunction

  assign ev0 = edge_ok(presc[ES0_LSB+:2], ti_lvl[0], ti_prev[0]);
  assign ev1 = edge_ok(presc[ES1_LSB+:2], ti_lvl[1], ti_prev[1]);

  // free-running prescaler shared by both divided rates
  always_ff @(posedge sys_clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
      pre_cnt <= RST_BYTE;
    else
      pre_cnt <= pre_cnt + 8'h01;
  end

  always_comb
  begin
    case (ck_sel)
      CK_DIV1: src = 1'b1;
      CK_DIV4: src = (pre_cnt[1:0] == DIV_MID_LAST[1:0]);
      CK_DIV256: src = (pre_cnt == DIV_SLOW_LAST);
      CK_EXT: src = ev0;
      default: src = 1'b0;
    endcase
  end

  // a pulse falling in a read is lost, not deferred: this keeps the
  // returned value stable at the cost of a small count error
  assign freeze = avs_read_in & (avs_address_in == A_COUNT);
  assign tick = (mode != MODE_STOP) & src & ~freeze;
  assign os_trig_w = wr_acc & (avs_address_in == A_OUTCTL)
    & avs_byteenable_in[0] & avs_writedata_in[OC_OS_TRIG]
    & avs_writedata_in[OC_OS_MODE];
  assign clr_match = (mode == MODE_CLR_MATCH) & (cnt == ccf);
  assign match_f = tick & (cnt == ccf) & ~ccctl[CC_F_CAP];
  assign match_s = tick & (cnt == ccs) & ~ccctl[CC_S_CAP];
  assign cap_f = ccctl[CC_F_CAP] & (ccctl[CC_F_SRC] ? ev0 : ev1);
  assign cap_s = ccctl[CC_S_CAP] & ev0;

  always_ff @(posedge sys_clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
      cnt <= RST_WORD;
    else if (mode == MODE_STOP)
      cnt <= RST_WORD;
    else if (os_trig_w)
      cnt <= RST_WORD;
    else if ((mode == MODE_CLR_EDGE) && ev0)
      cnt <= RST_WORD;
    else if (tick && clr_match)
      cnt <= RST_WORD;
    else if (tick)
      cnt <= cnt + 16'h0001;
  end

  // capture/compare registers: written by software or loaded by capture
  always_ff @(posedge sys_clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      ccf <= RST_WORD;
      ccs <= RST_WORD;
    end
    else
    begin
      if (cap_f)
        ccf <= cnt;
      else if (wr_acc && avs_address_in == A_CCF)
      begin
        if (avs_byteenable_in[0])
          ccf[7:0] <= avs_writedata_in[7:0];
        if (avs_byteenable_in[1])
          ccf[15:8] <= avs_writedata_in[15:8];
      end
      // only the input edge loads it; counter reads never do
      if (cap_s)
        ccs <= cnt;
      else if (wr_acc && avs_address_in == A_CCS)
      begin
        if (avs_byteenable_in[0])
          ccs[7:0] <= avs_writedata_in[7:0];
        if (avs_byteenable_in[1])
          ccs[15:8] <= avs_writedata_in[15:8];
      end
    end
  end

  // byte-wide control registers; the trigger bit is not stored
  always_ff @(posedge sys_clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      mode_reg <= RST_BYTE;
      ccctl <= RST_BYTE;
      outctl <= RST_BYTE;
      presc <= RST_BYTE;
      mask <= '0;
    end
    else if (wr_acc && avs_byteenable_in[0])
    begin
      case (avs_address_in)
        A_MODE: mode_reg <= avs_writedata_in[7:0];
        A_CCCTL: ccctl <= avs_writedata_in[7:0];
        A_OUTCTL: outctl <= avs_writedata_in[7:0] & 8'hFB;
        A_PRESC: presc <= avs_writedata_in[7:0];
        A_MASK: mask <= tec_irq_s'(avs_writedata_in[2:0]);
        default: ;
      endcase
    end
  end

  // timer output controller
  always_ff @(posedge sys_clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      timer_output_pin_out <= 1'b0;
      timer_output_pin_oe_out <= 1'b0;
      os_run <= 1'b0;
    end
    else
    begin
      timer_output_pin_oe_out <= outctl[OC_EN];
      if (!outctl[OC_EN])
      begin
        timer_output_pin_out <= outctl[OC_INIT];
        os_run <= 1'b0;
      end
      else if (os_trig_w)
      begin
        timer_output_pin_out <= outctl[OC_INIT];
        os_run <= 1'b1;
      end
      else if (outctl[OC_OS_MODE])
      begin
        // second match opens the pulse, first match ends the shot
        if (os_run && match_f)
        begin
          timer_output_pin_out <= outctl[OC_INIT];
          os_run <= 1'b0;
        end
        else if (os_run && match_s)
          timer_output_pin_out <= ~outctl[OC_INIT];
      end
      else if ((outctl[OC_TGL_F] & match_f) ^ (outctl[OC_TGL_S] & match_s))
        timer_output_pin_out <= ~timer_output_pin_out;
    end
  end

  // sticky status; a new event beats a clearing read in the same cycle
  assign ev.first = match_f | cap_f;
  assign ev.second = match_s | cap_s;
  assign ev.ovf = tick & (cnt == CNT_MAX) & ~clr_match;
  always_comb
  begin
    next_stat = stat;
    if (rd_acc && avs_address_in == A_STAT)
      next_stat = '0;
    next_stat = next_stat | ev;
  end

  always_ff @(posedge sys_clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      stat <= '0;
      irq_out <= 1'b0;
      match_irq_first_out <= 1'b0;
      match_irq_second_out <= 1'b0;
    end
    else
    begin
      stat <= next_stat;
      irq_out <= |(next_stat & mask);
      match_irq_first_out <= ev.first;
      match_irq_second_out <= ev.second;
    end
  end

  // every access waits one cycle; read data is caught as it arrives
  always_ff @(posedge sys_clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      avs_waitrequest_out <= 1'b1;
      avs_readdata_out <= '0;
    end
    else
    begin
      avs_waitrequest_out <= ~(req & avs_waitrequest_out);
      if (avs_read_in && avs_waitrequest_out)
      begin
        case (avs_address_in)
          A_COUNT: avs_readdata_out <= {16'h0000, cnt};
          A_CCF: avs_readdata_out <= {16'h0000, ccf};
          A_CCS: avs_readdata_out <= {16'h0000, ccs};
          A_MODE: avs_readdata_out <= {24'h000000, mode_reg};
          A_CCCTL: avs_readdata_out <= {24'h000000, ccctl};
          A_OUTCTL: avs_readdata_out <= {24'h000000, outctl};
          A_PRESC: avs_readdata_out <= {24'h000000, presc};
          A_STAT: avs_readdata_out <= {29'h00000000, stat};
          A_MASK: avs_readdata_out <= {29'h00000000, mask};
          default: avs_readdata_out <= '0;
        endcase
      end
    end
  end

  default clocking cb @(posedge sys_clk_in);
  endclocking
  default disable iff (!arst_n_in);

  a_stop_clears: assert property (
    mode == MODE_STOP |=> cnt == 16'h0000)
    else $error("counter not cleared in stop mode");
  a_count_step: assert property (
    (mode == MODE_FREE) && tick && !os_trig_w
    |=> cnt == $past(cnt) + 16'h0001)
    else $error("counter did not advance by one");
  a_read_freeze: assert property (
    (mode == MODE_FREE) && freeze |=> cnt == $past(cnt))
    else $error("counter moved during a read");
  a_edge_clear: assert property (
    (mode == MODE_CLR_EDGE) && ev0 && !os_trig_w |=> cnt == 16'h0000)
    else $error("valid edge did not clear counter");
  a_match_clear: assert property (
    tick && clr_match && !os_trig_w |=> cnt == 16'h0000)
    else $error("match did not clear counter");
  a_trig_clear: assert property (
    os_trig_w |=> cnt == 16'h0000 ##1 os_run || !outctl[OC_EN])
    else $error("one-shot trigger did not restart");
  a_read_no_cap: assert property (
    rd_acc && !cap_s |=> ccs == $past(ccs))
    else $error("read loaded second register");
  a_match_first: assert property (
    match_f |=> match_irq_first_out && stat.first)
    else $error("first match interrupt missing");
  a_match_second: assert property (
    match_s |=> match_irq_second_out && stat.second)
    else $error("second match interrupt missing");
  a_wrap_zero: assert property (
    (mode == MODE_FREE) && tick && cnt == CNT_MAX
    |=> cnt == 16'h0000 && stat.ovf)
    else $error("counter did not wrap");
  a_square_tgl: assert property (
    outctl[OC_EN] && !outctl[OC_OS_MODE]
    && outctl[OC_TGL_F] && !outctl[OC_TGL_S] && match_f && !os_trig_w
    |=> timer_output_pin_out != $past(timer_output_pin_out))
    else $error("square wave did not toggle");
  a_filter_two: assert property (
    $changed(ti_lvl[0])
    |-> $past(ti_raw[0], 2) == ti_lvl[0]
    && $past(ti_raw[0], 3) == ti_lvl[0])
    else $error("input level taken before two samples");
  a_bus_answer: assert property (req && avs_waitrequest_out
    |=> !avs_waitrequest_out)
    else $error("access not answered in one cycle");

  c_match_clear: cover property (tick && clr_match);
  c_one_shot: cover property (os_run && match_s ##[1:1000] match_f);
  c_capture: cover property (cap_f ##[1:1000] cap_s);
  c_irq: cover property (irq_out ##1 rd_acc);
endmodule
`default_nettype wire

// >>> testbench/tec_pulse_src.sv
`timescale 1ns/1ps
`default_nettype none
module tec_pulse_src (
  // clock
  input wire logic clk_in,
  // timer input levels
  output logic first_out,
  output logic second_out
);
  initial
  begin
    first_out = 1'b0;
    second_out = 1'b1;
  end
  // every level stays two clocks or more so the input filter keeps it
  task automatic burst(input int n, input int hi,
                       input int lo);
    repeat (n)
    begin
      @(posedge clk_in) first_out <= 1'b1;
      repeat (hi) @(posedge clk_in);
      first_out <= 1'b0;
      repeat (lo - 1) @(posedge clk_in);
    end
  endtask
  // second line follows the first inverted, so it also holds >= 2 clocks
  always @(posedge clk_in)
  begin
    second_out <= ~first_out;
  end
endmodule
`default_nettype wire

// >>> testbench/testbench.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) \
  begin \
    n_compared++; \
    if ((g) !== (e)) \
    begin \
      miscompares++; \
      $display("BAD %s expected %0h seen %0h", nm, e, g); \
    end \
  end
module testbench;
  import tec_pkg::*;
  logic sys_clk_in = 1'b0;
  logic arst_n_in = 1'b0;
  logic [17:0] av_adr = 18'h00000;
  logic av_rd = 1'b0;
  logic av_wr = 1'b0;
  logic [31:0] av_wd = 32'h00000000;
  logic [31:0] av_rdat;
  logic av_wait, ti1, ti2, tout, toe, irq, mf, ms;
  logic tprev = 1'b0;
  logic [31:0] seed = 32'h00000022;
  logic [31:0] q, q2;
  logic [7:0] oc [3] = '{8'h01, 8'h09, 8'h19};
  int miscompares = 0;
  int n_compared = 0;
  int cyc, t_f, p_f, t_s, p_s, t_r, p_r, w_hi, n_rise, i, n, w, k, a, b;

  always #2.5 sys_clk_in = ~sys_clk_in;

  tec_core tec_core_i (.sys_clk_in(sys_clk_in), .arst_n_in(arst_n_in),
    .avs_address_in(av_adr), .avs_read_in(av_rd), .avs_write_in(av_wr),
    .avs_writedata_in(av_wd), .avs_byteenable_in(4'hF),
    .avs_readdata_out(av_rdat), .avs_waitrequest_out(av_wait),
    .timer_input_first_in(ti1), .timer_input_second_in(ti2),
    .timer_output_pin_out(tout), .timer_output_pin_oe_out(toe),
    .irq_out(irq), .match_irq_first_out(mf), .match_irq_second_out(ms));
  tec_pulse_src tec_pulse_src_i (.clk_in(sys_clk_in), .first_out(ti1),
    .second_out(ti2));

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  // square wave toggles once per period of the interval
  function automatic int sq_period(input int cnt);
    return 2 * (cnt + 1);
  endfunction

  task automatic test_done();
    $display("compared %0d mismatches %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  // the bus cycle ends at the edge where waitrequest is seen low, or gives up after 20 edges
  task automatic bus(input logic w_en, input logic [17:0] ad,
                     input logic [31:0] d, output logic [31:0] r);
    int t;
    t = 0;
    @(posedge sys_clk_in);
    av_adr <= ad;
    av_wd <= d;
    av_wr <= w_en;
    av_rd <= ~w_en;
    do
    begin
      @(posedge sys_clk_in);
      t++;
    end
    while (av_wait !== 1'b0 && t < 20);
    r = av_rdat;
    av_wr <= 1'b0;
    av_rd <= 1'b0;
    if (t >= 20)
      miscompares++;
  endtask
  task automatic wr(input logic [17:0] ad, input logic [31:0] d);
    logic [31:0] r;
    bus(1'b1, ad, d, r);
  endtask
  task automatic rdchk(input string nm, input logic [17:0] ad,
                       input logic [31:0] e);
    logic [31:0] r;
    bus(1'b0, ad, 32'h00000000, r);
    `CHK(nm, e, r)
  endtask

  always @(posedge sys_clk_in)
  begin
    cyc++;
    if (mf === 1'b1)
    begin
      p_f = cyc - t_f;
      t_f = cyc;
    end
    if (ms === 1'b1)
    begin
      p_s = cyc - t_s;
      t_s = cyc;
    end
    if (tout === 1'b1 && tprev === 1'b0)
    begin
      p_r = cyc - t_r;
      t_r = cyc;
      n_rise++;
    end
    if (tout === 1'b0 && tprev === 1'b1)
      w_hi = cyc - t_r;
    tprev = tout;
    if (cyc == 80000)
    begin
      miscompares++;
      test_done();
    end
  end

  initial
  begin
    repeat (4) @(posedge sys_clk_in);
    arst_n_in <= 1'b1;
    rdchk("count", A_COUNT, 0);
    rdchk("ccf", A_CCF, 0);
    rdchk("ccs", A_CCS, 0);
    wr({16'hFF1E, 2'h0}, 32'h0000FFFF);
    rdchk("unmapped", {16'hFF1E, 2'h0}, 0);
    wr(A_COUNT, 32'h00001234);
    rdchk("count ro", A_COUNT, 0);
    for (i = 0; i < 3; i++)
    begin
      n = (i == 0) ? 1 : 3 + rnd() % 30;
      w = (i == 0) ? 1 : 2 + rnd() % (n - 2);
      wr(A_MODE, 0);
      wr(A_CCF, n);
      wr(A_CCS, w);
      wr(A_OUTCTL, oc[i]);
      wr(A_MODE, 32'h0000000C);
      repeat (6 * (n + 2)) @(posedge sys_clk_in);
      `CHK("interval", n + 1, p_f)
      `CHK("second", n + 1, p_s)
      `CHK("oe", 1'b1, toe)
      if (i == 1)
        `CHK("square", sq_period(n), p_r)
      if (i == 2)
        `CHK("ppg", n + 1, p_r)
    end
    wr(A_MASK, 1);
    repeat (n + 4) @(posedge sys_clk_in);
    `CHK("irq on", 1'b1, irq)
    bus(1'b0, A_STAT, 0, q);
    `CHK("stat", 1'b1, q[0])
    wr(A_MODE, 0);
    bus(1'b0, A_STAT, 0, q);
    repeat (3) @(posedge sys_clk_in);
    `CHK("irq off", 1'b0, irq)
    wr(A_MASK, 0);
    wr(A_MODE, 32'h00000004);
    bus(1'b0, A_COUNT, 0, q);
    bus(1'b0, A_COUNT, 0, q2);
    `CHK("freeze", 1'b1, q2 > q && q2 - q <= 2)
    wr(A_MODE, 0);
    rdchk("stop", A_COUNT, 0);
    k = 2 + rnd() % 10;
    wr(A_PRESC, 32'h00000013);
    wr(A_MODE, 32'h00000004);
    tec_pulse_src_i.burst(k, 2 + rnd() % 3, 2 + rnd() % 3);
    repeat (8) @(posedge sys_clk_in);
    rdchk("events", A_COUNT, k);
    wr(A_PRESC, 32'h00000030);
    wr(A_CCCTL, 32'h00000004);
    wr(A_MODE, 32'h00000008);
    repeat (50) @(posedge sys_clk_in);
    w = 2 + rnd() % 40;
    tec_pulse_src_i.burst(1, w, 4);
    repeat (10) @(posedge sys_clk_in);
    bus(1'b0, A_CCS, 0, q);
    `CHK("width", 1'b1, q >= w - 1 && q <= w + 1)
    bus(1'b0, A_COUNT, 0, q2);
    `CHK("edge clr", 1'b1, q2 < 32)
    rdchk("no load", A_CCS, q);
    wr(A_CCCTL, 0);
    wr(A_PRESC, 32'h00000001);
    wr(A_MODE, 0);
    wr(A_CCF, 32'h00000007);
    wr(A_MODE, 32'h0000000C);
    repeat (100) @(posedge sys_clk_in);
    `CHK("div4", 32, p_f)
    wr(A_MODE, 0);
    wr(A_CCF, 32'h00000001);
    wr(A_PRESC, 32'h00000002);
    wr(A_MODE, 32'h0000000C);
    repeat (1100) @(posedge sys_clk_in);
    `CHK("div256", 512, p_f)
    wr(A_PRESC, 0);
    a = 3 + rnd() % 20;
    b = a + 2 + rnd() % 20;
    wr(A_CCS, a);
    wr(A_CCF, b);
    wr(A_MODE, 32'h00000004);
    wr(A_OUTCTL, 32'h00000003);
    k = n_rise;
    wr(A_OUTCTL, 32'h00000007);
    repeat (b + 20) @(posedge sys_clk_in);
    `CHK("shots", 1, n_rise - k)
    `CHK("shot width", b - a, w_hi)
    wr(A_MODE, 0);
    wr(A_MODE, 32'h00000004);
    repeat (60) @(posedge sys_clk_in);
    wr(A_CCF, 32'h00000010);
    k = cyc;
    repeat (65600) @(posedge sys_clk_in);
    `CHK("wrap", 1'b1, t_f - k > 65400 && t_f - k <= 65536)
    bus(1'b0, A_STAT, 0, q);
    `CHK("ovf", 1'b1, q[2])
    arst_n_in <= 1'b0;
    repeat (4) @(posedge sys_clk_in);
    arst_n_in <= 1'b1;
    rdchk("count rst", A_COUNT, 0);
    rdchk("ccf rst", A_CCF, 0);
    test_done();
  end
endmodule
`default_nettype wire
